// ### verilog/timer_cmp_pkg.sv
// constants shared by the compare, one-pulse and pwm logic
package timer_cmp_pkg;
   localparam logic [15:0] COMPARE_RESET_VALUE = 16'h8000;
   localparam logic [15:0] COUNTER_RELOAD      = 16'hFFFC;
   localparam logic [15:0] CAPTURE_PULSE_VALUE = 16'hFFFD;
   localparam logic [15:0] COUNTER_STEP        = 16'h0001;
   localparam logic [1:0]  CLOCK_SEL_DIV2      = 2'h1;
   localparam int          CHANNELS            = 2;
   localparam int          CH_ONE              = 0;
   localparam int          CH_TWO              = 1;
   localparam int          BYTE_W              = 8;
endpackage : timer_cmp_pkg

// ### verilog/compare_link_if.sv
// link between the timer top and one compare channel
`timescale 1ns/1ps
`default_nettype none
interface compare_link_if;
   logic [7:0]  wr_data;
   logic        wr_high;
   logic        wr_low;
   logic [15:0] counter;
   logic        div2;
   logic        pwm;
   logic        reload;
   logic [15:0] value;
   logic        match;
   logic        inhibit;

   modport top
   (
      output wr_data, wr_high, wr_low, counter, div2, pwm, reload,
      input  value, match, inhibit
   );
   modport channel
   (
      input  wr_data, wr_high, wr_low, counter, div2, pwm, reload,
      output value, match, inhibit
   );
endinterface : compare_link_if
`default_nettype wire

// ### verilog/compare_channel.sv
// one 16-bit compare channel: byte writes, inhibit, double buffer, match
`timescale 1ns/1ps
`default_nettype none
module compare_channel
(
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   // link to timer top
   compare_link_if.channel  link
);
   typedef struct packed {
      logic [15:0] value;
      logic [15:0] active;
      logic        inhibit;
      logic        eq_prev;
   } chan_state_t;

   chan_state_t state;
   chan_state_t next_state;
   logic [15:0] target;
   logic        equal;

   // every clock select except div2 sees the match one count late
   assign target = link.div2 ? state.active
                             : state.active + timer_cmp_pkg::COUNTER_STEP;
   assign equal  = (link.counter == target);

   // a match is the first cycle of equality, never while half written
   assign link.match   = equal & ~state.eq_prev & ~state.inhibit;
   assign link.value   = state.value;
   assign link.inhibit = state.inhibit;

   always_comb
   begin
      next_state         = state;
      next_state.eq_prev = equal;
      if (link.wr_high)
      begin
         next_state.value[15:8] = link.wr_data;
         next_state.inhibit     = 1'b1;
      end
      if (link.wr_low)
      begin
         next_state.value[7:0] = link.wr_data;
         next_state.inhibit    = 1'b0;
      end
      // pwm holds the old pair until the period ends, avoiding spikes
      if (!link.pwm)
         next_state.active = next_state.value;
      else if (link.reload && !state.inhibit)
         next_state.active = state.value;
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         state.value   <= timer_cmp_pkg::COMPARE_RESET_VALUE;
         state.active  <= timer_cmp_pkg::COMPARE_RESET_VALUE;
         state.inhibit <= 1'b0;
         state.eq_prev <= 1'b0;
      end
      else
         state <= next_state;
   end
endmodule // compare_channel
`default_nettype wire

// ### verilog/timer_compare_pulse_pwm.sv
// compare, one-pulse and pwm section of a 16-bit free-running timer
`timescale 1ns/1ps
`default_nettype none
module timer_compare_pulse_pwm
(
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   // processor byte accesses
   input  wire logic [7:0]  byte_data_i,
   input  wire logic [1:0]  compare_high_write_i,
   input  wire logic [1:0]  compare_low_write_i,
   input  wire logic [1:0]  compare_low_read_i,
   input  wire logic [1:0]  capture_low_access_i,
   input  wire logic        status_read_i,
   // control bits
   input  wire logic [1:0]  compare_pin_enable_i,
   input  wire logic [1:0]  output_level_bit_i,
   input  wire logic [1:0]  force_output_bit_i,
   input  wire logic        one_pulse_select_i,
   input  wire logic        pwm_select_i,
   input  wire logic [1:0]  timer_clock_select_i,
   input  wire logic [1:0]  capture_edge_select_i,
   // free-running counter
   input  wire logic [15:0] counter_i,
   output logic             counter_load_o,
   output logic [15:0]      counter_load_value_o,
   // capture pins
   input  wire logic        capture_input_one_i,
   input  wire logic        capture_input_two_i,
   // register contents and status
   output logic [15:0]      compare_value_one_o,
   output logic [15:0]      compare_value_two_o,
   output logic [15:0]      capture_value_one_o,
   output logic [15:0]      capture_value_two_o,
   output logic [1:0]       compare_flag_o,
   output logic [1:0]       capture_flag_o,
   // compare pins
   output logic [1:0]       compare_output_pin_o,
   output logic [1:0]       compare_output_oe_o
);
   localparam int ONE = timer_cmp_pkg::CH_ONE;
   localparam int TWO = timer_cmp_pkg::CH_TWO;

   typedef struct packed {
      logic [1:0]       compare_flag;
      logic [1:0]       capture_flag;
      logic [1:0]       compare_armed;
      logic [1:0]       capture_armed;
      logic [1:0]       pin;
      logic [1:0]       input_prev;
      logic [1:0][15:0] capture_value;
   } top_state_t;

   top_state_t state;
   top_state_t next_state;

   compare_link_if link [timer_cmp_pkg::CHANNELS] ();

   // active edge on a capture input, per its edge select
   function automatic logic edge_seen(input logic prev, input logic cur, input logic rising);
      edge_seen = rising ? (cur & ~prev) : (prev & ~cur);
   endfunction

   logic       mode_pwm;
   logic       mode_pulse;
   logic       mode_normal;
   logic       div2;
   logic [1:0] match;
   logic [1:0] input_now;
   logic [1:0] edge_hit;
   logic [1:0] compare_access;
   logic       pulse_trigger;
   logic       period_end;

   assign mode_pwm    = pwm_select_i;
   assign mode_pulse  = one_pulse_select_i & ~pwm_select_i;
   assign mode_normal = ~mode_pwm & ~mode_pulse;
   assign div2        = (timer_clock_select_i == timer_cmp_pkg::CLOCK_SEL_DIV2);
   assign input_now   = {capture_input_two_i, capture_input_one_i};
   assign compare_access = compare_low_write_i | compare_low_read_i;

   genvar g;
   generate
      for (g = 0; g < timer_cmp_pkg::CHANNELS; g++)
      begin : g_chan
         assign link[g].wr_data = byte_data_i;
         assign link[g].wr_high = compare_high_write_i[g];
         assign link[g].wr_low  = compare_low_write_i[g];
         assign link[g].counter = counter_i;
         assign link[g].div2    = div2;
         assign link[g].pwm     = mode_pwm;
         assign link[g].reload  = period_end;
         assign match[g]        = link[g].match;
         assign edge_hit[g]     = edge_seen(state.input_prev[g], input_now[g],
                                            capture_edge_select_i[g]);
         compare_channel u_chan
         (
            .mclk_i  (mclk_i),
            .reset_i (reset_i),
            .link    (link[g].channel)
         );
      end
   endgenerate

   // compare two ends each pwm period
   assign period_end    = mode_pwm & match[TWO];
   // input one is only a trigger in one-pulse mode
   assign pulse_trigger = mode_pulse & edge_hit[ONE];

   // counter core is outside; reload is a same-cycle request
   assign counter_load_o       = period_end | pulse_trigger;
   assign counter_load_value_o = timer_cmp_pkg::COUNTER_RELOAD;

   always_comb
   begin
      logic [1:0] cmp_set;
      logic [1:0] cap_set;
      logic [1:0] cmp_clear;
      logic [1:0] cap_clear;
      cmp_set   = 2'h0;
      cap_set   = 2'h0;
      cmp_clear = 2'h0;
      cap_clear = 2'h0;

      next_state            = state;
      next_state.input_prev = input_now;

      // compare flags: never in pwm, only channel two in one-pulse
      cmp_set[ONE] = match[ONE] & mode_normal;
      cmp_set[TWO] = match[TWO] & ~mode_pwm;

      // channel one capture source depends on mode
      if (mode_normal && edge_hit[ONE])
      begin
         cap_set[ONE]                = 1'b1;
         next_state.capture_value[ONE] = counter_i;
      end
      if (pulse_trigger)
      begin
         cap_set[ONE]                  = 1'b1;
         next_state.capture_value[ONE] = timer_cmp_pkg::CAPTURE_PULSE_VALUE;
      end
      if (period_end)
         cap_set[ONE] = 1'b1;
      // input two captures in every mode
      if (edge_hit[TWO])
      begin
         cap_set[TWO]                  = 1'b1;
         next_state.capture_value[TWO] = counter_i;
      end

      // two-step clear; a set in the clearing cycle wins
      cmp_clear = state.compare_armed & compare_access;
      cap_clear = state.capture_armed & capture_low_access_i;
      next_state.compare_flag = cmp_set | (state.compare_flag & ~cmp_clear);
      next_state.capture_flag = cap_set | (state.capture_flag & ~cap_clear);
      next_state.compare_armed = (status_read_i ? state.compare_flag : 2'h0)
                               | (state.compare_armed & ~compare_access);
      next_state.capture_armed = (status_read_i ? state.capture_flag : 2'h0)
                               | (state.capture_armed & ~capture_low_access_i);

      // pin latches change only while the pin is enabled
      if (mode_normal)
      begin
         for (int i = 0; i < timer_cmp_pkg::CHANNELS; i++)
         begin
            if (compare_pin_enable_i[i] && (match[i] || force_output_bit_i[i]))
               next_state.pin[i] = output_level_bit_i[i];
         end
      end
      else if (compare_pin_enable_i[ONE])
      begin
         // force bits are not looked at here
         if (mode_pulse && pulse_trigger)
            next_state.pin[ONE] = output_level_bit_i[TWO];
         else if (mode_pulse && match[ONE])
            next_state.pin[ONE] = output_level_bit_i[ONE];
         else if (mode_pwm && match[TWO])
            next_state.pin[ONE] = output_level_bit_i[TWO];
         else if (mode_pwm && match[ONE])
            next_state.pin[ONE] = output_level_bit_i[ONE];
      end
      // channel two pin is left alone outside normal mode
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         state.compare_flag  <= 2'h0;
         state.capture_flag  <= 2'h0;
         state.compare_armed <= 2'h0;
         state.capture_armed <= 2'h0;
         state.pin           <= 2'h0;
         state.input_prev    <= 2'h0;
         state.capture_value <= '0;
      end
      else
         state <= next_state;
   end

   assign compare_value_one_o  = link[ONE].value;
   assign compare_value_two_o  = link[TWO].value;
   assign capture_value_one_o  = state.capture_value[ONE];
   assign capture_value_two_o  = state.capture_value[TWO];
   assign compare_flag_o       = state.compare_flag;
   assign capture_flag_o       = state.capture_flag;
   assign compare_output_pin_o = state.pin;
   // disabled pin stays general I/O
   assign compare_output_oe_o  = compare_pin_enable_i;
endmodule // timer_compare_pulse_pwm
`default_nettype wire

// ### sim/timer_counter_model.sv
// behavioural counter core on the far side of the compare block
`timescale 1ns/1ps
`default_nettype none
module timer_counter_model
(
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   // reload request
   input  wire logic        load_i,
   input  wire logic [15:0] load_value_i,
   // current count
   output logic [15:0]      count_o
);
   // counts every cycle, so a timer step is one mclk here
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         count_o <= 16'h0000;
      else if (load_i)
         count_o <= load_value_i;
      else
         count_o <= count_o + 16'h0001;
   end
endmodule // timer_counter_model
`default_nettype wire

// ### sim/timer_compare_pulse_pwm_assertions.sv
// concurrent checks on the compare, one-pulse and pwm timer ports
`timescale 1ns/1ps
`default_nettype none
module timer_compare_pulse_pwm_checker
(
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   // control bits
   input  wire logic [1:0]  compare_pin_enable_i,
   input  wire logic [1:0]  output_level_bit_i,
   input  wire logic        one_pulse_select_i,
   input  wire logic        pwm_select_i,
   // watched outputs
   input  wire logic        counter_load_o,
   input  wire logic [15:0] counter_load_value_o,
   input  wire logic [15:0] capture_value_one_o,
   input  wire logic [1:0]  compare_flag_o,
   input  wire logic [1:0]  capture_flag_o,
   input  wire logic [1:0]  compare_output_pin_o,
   input  wire logic [1:0]  compare_output_oe_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   sequence pulse_trigger;
      counter_load_o && one_pulse_select_i && !pwm_select_i;
   endsequence
   // capture result may trail the load request by a few edges
   sequence pulse_loaded;
      capture_flag_o[0] && capture_value_one_o == timer_cmp_pkg::CAPTURE_PULSE_VALUE;
   endsequence
   pin_enable_follow_a: assert property (compare_output_oe_o == compare_pin_enable_i)
      else $error("pin enable not mirrored");
   pwm_no_flag_a: assert property (|(compare_flag_o & ~$past(compare_flag_o)) |-> !$past(pwm_select_i))
      else $error("compare flag set in pwm");
   pulse_no_flag_a: assert property ($rose(compare_flag_o[0]) |-> !$past(one_pulse_select_i))
      else $error("compare flag one set in one-pulse");
   reload_value_a: assert property (counter_load_value_o == timer_cmp_pkg::COUNTER_RELOAD)
      else $error("wrong reload value");
   reload_cause_a: assert property (counter_load_o |-> pwm_select_i || one_pulse_select_i)
      else $error("reload outside special modes");
   pulse_start_a: assert property (pulse_trigger |-> ##[0:3] pulse_loaded)
      else $error("one-pulse trigger did not capture");
   period_flag_a: assert property (counter_load_o && pwm_select_i |-> ##[0:3] capture_flag_o[0])
      else $error("period end did not flag");
   period_pin_a: assert property (
      counter_load_o && pwm_select_i && compare_pin_enable_i[0]
      |=> compare_output_pin_o[0] == $past(output_level_bit_i[1]))
      else $error("period end pin level wrong");
endmodule // timer_compare_pulse_pwm_checker
bind timer_compare_pulse_pwm timer_compare_pulse_pwm_checker timer_compare_pulse_pwm_checker_inst
(
   .mclk_i(mclk_i), .reset_i(reset_i), .compare_pin_enable_i(compare_pin_enable_i),
   .output_level_bit_i(output_level_bit_i), .one_pulse_select_i(one_pulse_select_i),
   .pwm_select_i(pwm_select_i), .counter_load_o(counter_load_o),
   .counter_load_value_o(counter_load_value_o), .capture_value_one_o(capture_value_one_o),
   .compare_flag_o(compare_flag_o), .capture_flag_o(capture_flag_o),
   .compare_output_pin_o(compare_output_pin_o), .compare_output_oe_o(compare_output_oe_o)
);
`default_nettype wire

// ### sim/timer_compare_pulse_pwm_tb_top.sv
// self-checking bench for the compare, one-pulse and pwm timer section
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module timer_compare_pulse_pwm_tb_top;
   logic        mclk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [7:0]  bd = 8'h00;
   logic [1:0]  hw = 2'h0, lw = 2'h0, lr = 2'h0, ca = 2'h0, pen = 2'h1, lvl = 2'h3, frc = 2'h0;
   logic [1:0]  csel = 2'h1, edg = 2'h3, cflag, kflag, pin, oe;
   logic        st = 1'b0, one_pulse_select = 1'b0, pwm = 1'b0, cap1 = 1'b0, cap2 = 1'b0, ld;
   logic [15:0] cnt, ldv, cv1, cv2, kv1, kv2, v;
   int          fails = 0;
   int          n_compared = 0;
   timer_compare_pulse_pwm timer_compare_pulse_pwm_inst
   (
      .mclk_i(mclk_i), .reset_i(reset_i), .byte_data_i(bd), .compare_high_write_i(hw),
      .compare_low_write_i(lw), .compare_low_read_i(lr), .capture_low_access_i(ca),
      .status_read_i(st), .compare_pin_enable_i(pen), .output_level_bit_i(lvl),
      .force_output_bit_i(frc), .one_pulse_select_i(one_pulse_select), .pwm_select_i(pwm),
      .timer_clock_select_i(csel), .capture_edge_select_i(edg), .counter_i(cnt),
      .counter_load_o(ld), .counter_load_value_o(ldv), .capture_input_one_i(cap1),
      .capture_input_two_i(cap2), .compare_value_one_o(cv1), .compare_value_two_o(cv2),
      .capture_value_one_o(kv1), .capture_value_two_o(kv2), .compare_flag_o(cflag),
      .capture_flag_o(kflag), .compare_output_pin_o(pin), .compare_output_oe_o(oe)
   );
   timer_counter_model timer_counter_model_inst
   (
      .mclk_i(mclk_i), .reset_i(reset_i), .load_i(ld), .load_value_i(ldv), .count_o(cnt)
   );
   initial
   begin
      forever #4 mclk_i = ~mclk_i;
   end
   task automatic tick(input int n = 1);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic wr(input int ch, input logic [15:0] val);
      bd = val[15:8];
      hw[ch] = 1'b1;
      tick();
      hw = 2'h0;
      bd = val[7:0];
      lw[ch] = 1'b1;
      tick();
      lw = 2'h0;
   endtask
   // status read first, then a spare cycle, then the low-byte access
   task automatic clr(input bit cap, input int ch);
      st = 1'b1;
      tick();
      st = 1'b0;
      tick();
      if (cap) ca[ch] = 1'b1;
      else lr[ch] = 1'b1;
      tick();
      ca = 2'h0;
      lr = 2'h0;
      tick();
   endtask
   task automatic wait_cnt(input logic [15:0] val);
      for (int k = 0; k < 600 && cnt !== val; k++) tick();
   endtask
   task automatic t_match();
      v = cnt + 16'h0030;
      wr(0, v);
      wr(1, v + 16'h0010);
      `CHK({cv1, cv2}, {v, v + 16'h0010})
      wait_cnt(v);
      tick();
      `CHK({cflag[0], pin[0]}, 2'h3)
      csel = 2'h2;
      wait_cnt(v + 16'h0010);
      tick();
      `CHK(cflag[1], 1'b0)
      tick();
      `CHK({cflag[1], pin[1], oe}, 4'h9)
      csel = 2'h1;
      lr[0] = 1'b1;
      tick();
      lr = 2'h0;
      clr(0, 1);
      `CHK(cflag, 2'h1)
      clr(0, 0);
      `CHK(cflag, 2'h0)
   endtask
   task automatic t_inhibit_force();
      v = cnt + 16'h0020;
      wr(0, v);
      bd = v[15:8];
      hw[0] = 1'b1;
      tick();
      hw = 2'h0;
      wait_cnt(v + 16'h0002);
      tick();
      `CHK(cflag[0], 1'b0)
      lvl = 2'h0;
      frc = 2'h1;
      tick(2);
      `CHK({pin[0], cflag}, 3'h0)
      one_pulse_select = 1'b1;
      lvl = 2'h3;
      tick(2);
      `CHK(pin[0], 1'b0)
      frc = 2'h0;
   endtask
   task automatic t_pulse();
      lvl = 2'h2;
      wr(0, 16'h0010);
      cap1 = 1'b1;
      wait_cnt(16'hFFFC);
      tick(2);
      `CHK({pin[0], kflag[0], kv1}, 18'h3FFFD)
      wait_cnt(16'h0010);
      tick(2);
      `CHK({pin[0], cflag[0]}, 2'h0)
      v = cnt;
      cap2 = 1'b1;
      tick(3);
      `CHK(kflag[1], 1'b1)
      `CHK(kv2, v)
      clr(1, 0);
      `CHK(kflag[0], 1'b0)
   endtask
   task automatic t_pwm();
      cap1 = 1'b0;
      tick();
      cap1 = 1'b1;
      wr(0, 16'h0008);
      wr(1, 16'h0040);
      pwm = 1'b1;
      clr(0, 1);
      clr(1, 0);
      wait_cnt(16'h0040);
      tick();
      `CHK(cnt, 16'hFFFC)
      tick();
      `CHK({kflag[0], pin[0], cflag}, 4'hC)
      wr(0, 16'h0010);
      wait_cnt(16'h000C);
      `CHK(pin[0], 1'b0)
      tick();
      wait_cnt(16'h000C);
      `CHK(pin[0], 1'b1)
      wait_cnt(16'h0012);
      `CHK(pin[0], 1'b0)
   endtask
   task automatic tally_and_finish();
      if (fails == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge mclk_i);
      #1 reset_i = 1'b0;
      tick();
      `CHK({cv1, cv2, kflag, cflag, pin}, {16'h8000, 16'h8000, 6'h00})
      t_match();
      t_inhibit_force();
      t_pulse();
      t_pwm();
      tally_and_finish();
   end
   // whole run is a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge mclk_i);
      fails++;
      tally_and_finish();
   end
endmodule // timer_compare_pulse_pwm_tb_top
`default_nettype wire
